// file: logic/ovr_pkg.sv
package ovr_pkg;
    // Register indices, not byte offsets; byte address is 4x index
    localparam logic [15:0] OVR_IDX_GAIN_A = 16'hfe1c;
    localparam logic [15:0] OVR_IDX_GAIN_B = 16'hfe1d;
    localparam logic [15:0] OVR_IDX_MAX_A = 16'hfe1e;
    localparam logic [15:0] OVR_IDX_MAX_B = 16'hfe1f;
    localparam logic [15:0] OVR_IDX_MIN_A = 16'hfe20;
    localparam logic [15:0] OVR_IDX_MIN_B = 16'hfe21;
    localparam logic [15:0] OVR_IDX_REFH_A = 16'hfe22;
    localparam logic [15:0] OVR_IDX_REFH_B = 16'hfe23;
    localparam logic [15:0] OVR_IDX_REFL_A = 16'hfe24;
    localparam logic [15:0] OVR_IDX_REFL_B = 16'hfe25;
    localparam logic [15:0] OVR_IDX_SENSE_A = 16'hfe30;
    localparam logic [15:0] OVR_IDX_SENSE_B = 16'hfe31;
    localparam logic [15:0] OVR_IDX_EFF_A = 16'hfe32;
    localparam logic [15:0] OVR_IDX_EFF_B = 16'hfe33;
    localparam logic [15:0] OVR_IDX_BASE = 16'hfe1c;
    localparam int OVR_NUM_REGS = 24;
    localparam int OVR_GAIN_SIGN_BIT = 7;
    localparam int OVR_GAIN_MAG_W = 7;
    localparam int OVR_LIMIT_W = 6;
    localparam int OVR_REF_W = 12;
    localparam int OVR_REFL_W = 4;
    localparam logic [7:0] OVR_RST_GAIN = 8'h00;
    localparam logic [7:0] OVR_RST_MAX = 8'h3f;
    localparam logic [7:0] OVR_RST_MIN = 8'h00;
    localparam logic [7:0] OVR_RST_REFH = 8'h00;
    localparam logic [7:0] OVR_RST_REFL = 8'h00;
    localparam logic [1:0] OVR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] OVR_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic sign;
        logic [6:0] mag;
    } ovr_gain_t;

    typedef struct packed {
        ovr_gain_t gain;
        logic [5:0] max_lim;
        logic [5:0] min_lim;
        logic [11:0] ref_val;
    } ovr_chan_cfg_t;
endpackage : ovr_pkg

// file: logic/ovr_gain_trim.sv
module ovr_gain_trim
    import ovr_pkg::*;
(
    input wire logic [11:0] raw,
    input wire ovr_gain_t gain,
    output logic [11:0] trimmed
);
    // Correction is raw * mag / 1024, roughly 0.1 percent per step
    logic [18:0] prod;
    logic [11:0] delta;
    logic [12:0] sum_up;
    assign prod = raw * gain.mag;
    assign delta = {3'h0, prod[18:10]};
    assign sum_up = {1'b0, raw} + {1'b0, delta};
    assign trimmed = gain.sign ? (raw - delta)
        : (sum_up[12] ? 12'hfff : sum_up[11:0]);
endmodule : ovr_gain_trim

// file: logic/ovr_ref_clamp.sv
module ovr_ref_clamp
    import ovr_pkg::*;
(
    input wire logic [11:0] ref_in,
    input wire logic [5:0] max_lim,
    input wire logic [5:0] min_lim,
    output logic [11:0] ref_out
);
    logic above;
    logic below;
    assign above = ref_in[11:6] > max_lim;
    assign below = ref_in[11:6] < min_lim;
    // Upper bound wins if limits are crossed and ref_in[11:6] is above max_lim; at or below it the min_lim clamp applies
    assign ref_out = above ? {max_lim, 6'h3f}
        : (below ? {min_lim, 6'h00} : ref_in);
endmodule : ovr_ref_clamp

// file: logic/ovr_regs.sv
module ovr_regs
    import ovr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [11:0] first_output_sense_raw,
    input wire logic [11:0] second_output_sense_raw,
    output logic [11:0] first_output_sense_trimmed,
    output logic [11:0] second_output_sense_trimmed,
    output logic [11:0] first_output_ref,
    output logic [11:0] second_output_ref,
    output logic signed [12:0] first_output_error,
    output logic signed [12:0] second_output_error
);
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [7:0] max_a;
    logic [7:0] max_b;
    logic [7:0] min_a;
    logic [7:0] min_b;
    logic [7:0] refh_a;
    logic [7:0] refh_b;
    logic [7:0] refl_a;
    logic [7:0] refl_b;

    function automatic logic [15:0] word_index(input logic [31:0] a);
        word_index = a[17:2];
    endfunction : word_index

    function automatic logic signed [12:0] diff(input logic [11:0] r,
                                                 input logic [11:0] s);
        diff = $signed({1'b0, r}) - $signed({1'b0, s});
    endfunction : diff

    // Address phase capture
    logic wr_pend;
    logic [15:0] wr_idx;
    wire take = hsel && hready && htrans == OVR_HTRANS_NONSEQ;
    wire [15:0] addr_idx = word_index(haddr);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 16'h0000;
        end
        else
        begin
            wr_pend <= take && hwrite;
            wr_idx <= addr_idx;
        end
    end

    wire [7:0] wb = hwdata[7:0];
    wire we_gain_a = wr_pend && wr_idx == OVR_IDX_GAIN_A;
    wire we_gain_b = wr_pend && wr_idx == OVR_IDX_GAIN_B;
    wire we_max_a = wr_pend && wr_idx == OVR_IDX_MAX_A;
    wire we_max_b = wr_pend && wr_idx == OVR_IDX_MAX_B;
    wire we_min_a = wr_pend && wr_idx == OVR_IDX_MIN_A;
    wire we_min_b = wr_pend && wr_idx == OVR_IDX_MIN_B;
    wire we_refh_a = wr_pend && wr_idx == OVR_IDX_REFH_A;
    wire we_refh_b = wr_pend && wr_idx == OVR_IDX_REFH_B;
    wire we_refl_a = wr_pend && wr_idx == OVR_IDX_REFL_A;
    wire we_refl_b = wr_pend && wr_idx == OVR_IDX_REFL_B;

    // Next values; reserved bits stay read/write as storage
    wire [7:0] next_gain_a = we_gain_a ? wb : gain_a;
    wire [7:0] next_gain_b = we_gain_b ? wb : gain_b;
    wire [7:0] next_max_a = we_max_a ? wb : max_a;
    wire [7:0] next_max_b = we_max_b ? wb : max_b;
    wire [7:0] next_min_a = we_min_a ? wb : min_a;
    wire [7:0] next_min_b = we_min_b ? wb : min_b;
    wire [7:0] next_refh_a = we_refh_a ? wb : refh_a;
    wire [7:0] next_refh_b = we_refh_b ? wb : refh_b;
    wire [7:0] next_refl_a = we_refl_a ? wb : refl_a;
    wire [7:0] next_refl_b = we_refl_b ? wb : refl_b;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gain_a <= OVR_RST_GAIN;
        else
            gain_a <= next_gain_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gain_b <= OVR_RST_GAIN;
        else
            gain_b <= next_gain_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            max_a <= OVR_RST_MAX;
        else
            max_a <= next_max_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            max_b <= OVR_RST_MAX;
        else
            max_b <= next_max_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            min_a <= OVR_RST_MIN;
        else
            min_a <= next_min_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            min_b <= OVR_RST_MIN;
        else
            min_b <= next_min_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            refh_a <= OVR_RST_REFH;
        else
            refh_a <= next_refh_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            refh_b <= OVR_RST_REFH;
        else
            refh_b <= next_refh_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            refl_a <= OVR_RST_REFL;
        else
            refl_a <= next_refl_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            refl_b <= OVR_RST_REFL;
        else
            refl_b <= next_refl_b;
    end

    ovr_chan_cfg_t cfg_a;
    ovr_chan_cfg_t cfg_b;
    assign cfg_a = '{gain: gain_a, max_lim: max_a[5:0],
                     min_lim: min_a[5:0], ref_val: {refh_a, refl_a[3:0]}};
    assign cfg_b = '{gain: gain_b, max_lim: max_b[5:0],
                     min_lim: min_b[5:0], ref_val: {refh_b, refl_b[3:0]}};

    logic [11:0] trim_a;
    logic [11:0] trim_b;
    ovr_gain_trim u_trim_a (
        .raw(first_output_sense_raw),
        .gain(cfg_a.gain),
        .trimmed(trim_a)
    );
    ovr_gain_trim u_trim_b (
        .raw(second_output_sense_raw),
        .gain(cfg_b.gain),
        .trimmed(trim_b)
    );

    logic [11:0] eff_a;
    logic [11:0] eff_b;
    ovr_ref_clamp u_clamp_a (
        .ref_in(cfg_a.ref_val),
        .max_lim(cfg_a.max_lim),
        .min_lim(cfg_a.min_lim),
        .ref_out(eff_a)
    );
    ovr_ref_clamp u_clamp_b (
        .ref_in(cfg_b.ref_val),
        .max_lim(cfg_b.max_lim),
        .min_lim(cfg_b.min_lim),
        .ref_out(eff_b)
    );

    // Read mux; unmapped words read zero
    logic [11:0] rd_val;
    always_comb
    begin
        case (addr_idx)
            OVR_IDX_GAIN_A: rd_val = {4'h0, gain_a};
            OVR_IDX_GAIN_B: rd_val = {4'h0, gain_b};
            OVR_IDX_MAX_A: rd_val = {4'h0, max_a};
            OVR_IDX_MAX_B: rd_val = {4'h0, max_b};
            OVR_IDX_MIN_A: rd_val = {4'h0, min_a};
            OVR_IDX_MIN_B: rd_val = {4'h0, min_b};
            OVR_IDX_REFH_A: rd_val = {4'h0, refh_a};
            OVR_IDX_REFH_B: rd_val = {4'h0, refh_b};
            OVR_IDX_REFL_A: rd_val = {4'h0, refl_a};
            OVR_IDX_REFL_B: rd_val = {4'h0, refl_b};
            OVR_IDX_SENSE_A: rd_val = trim_a;
            OVR_IDX_SENSE_B: rd_val = trim_b;
            OVR_IDX_EFF_A: rd_val = eff_a;
            OVR_IDX_EFF_B: rd_val = eff_b;
            default: rd_val = 12'h000;
        endcase
    end

    // Read data loads only on a read address phase
    wire [31:0] next_hrdata = (take && !hwrite) ? {20'h00000, rd_val}
        : hrdata;
    wire signed [12:0] next_first_output_error = diff(eff_a, trim_a);
    wire signed [12:0] next_second_output_error = diff(eff_b, trim_b);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else
            hrdata <= next_hrdata;
    end

    // Zero wait states; response always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            first_output_sense_trimmed <= 12'h000;
        else
            first_output_sense_trimmed <= trim_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            second_output_sense_trimmed <= 12'h000;
        else
            second_output_sense_trimmed <= trim_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            first_output_ref <= 12'h000;
        else
            first_output_ref <= eff_a;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            second_output_ref <= 12'h000;
        else
            second_output_ref <= eff_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            first_output_error <= 13'sh0;
        else
            first_output_error <= next_first_output_error;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            second_output_error <= 13'sh0;
        else
            second_output_error <= next_second_output_error;
    end
endmodule : ovr_regs

// file: verification/ovr_regs_properties.sv
module ovr_regs_properties
    import ovr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [11:0] first_output_sense_raw,
    input wire logic [11:0] first_output_sense_trimmed,
    input wire logic [11:0] first_output_ref,
    input wire logic signed [12:0] first_output_error
);
    logic up;
    wire take = hsel && hready && htrans == OVR_HTRANS_NONSEQ;
    wire rd_take = take && !hwrite;
    wire wr_take = take && hwrite;
    // Trim pipeline holds reset data on the first edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            up <= 1'b0;
        else
            up <= 1'b1;
    end
    // Any trim code stays within 127/1024 of the raw reading
    function automatic bit in_band(logic [11:0] r, logic [11:0] t);
        int d;
        d = (int'(r) * 127) >>> 10;
        return int'(t) >= int'(r) - d && int'(t) <= int'(r) + d;
    endfunction : in_band
    sequence s_bus_quiet;
        !wr_take [*4];
    endsequence
    sequence s_loop_steady;
        ($stable(first_output_ref) &&
        $stable(first_output_sense_trimmed)) [*3];
    endsequence
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp)
        else $error("error response given");
    a_rdata_upper: assert property (hrdata[31:12] == 20'h0)
        else $error("read data upper bits set");
    a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_trim_zero: assert property (
        $past(first_output_sense_raw) == 12'h0 |->
        first_output_sense_trimmed == 12'h0)
        else $error("zero reading trimmed to nonzero");
    a_trim_band: assert property (
        up |-> in_band($past(first_output_sense_raw),
        first_output_sense_trimmed))
        else $error("trimmed reading out of band");
    a_error_diff: assert property (
        s_loop_steady |-> first_output_error ==
        $signed({1'b0, first_output_ref}) -
        $signed({1'b0, first_output_sense_trimmed}))
        else $error("loop error not reference minus sense");
    a_ref_quiet: assert property (s_bus_quiet |=> $stable(first_output_ref))
        else $error("reference moved without a write");
    a_reset_clear: assert property (
        $rose(hresetn) |-> first_output_ref == 12'h0 && hrdata == 32'h0)
        else $error("outputs not clear after reset");
endmodule : ovr_regs_properties

bind ovr_regs ovr_regs_properties i_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .first_output_sense_raw(first_output_sense_raw),
    .first_output_sense_trimmed(first_output_sense_trimmed),
    .first_output_ref(first_output_ref),
    .first_output_error(first_output_error)
);

// file: verification/ovr_regs_bench.sv
module ovr_regs_bench
    import ovr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp;
    logic [11:0] raw_a = 12'h0, raw_b = 12'h0, trim_a, trim_b, ref_a, ref_b;
    logic signed [12:0] err_a, err_b;
    int bad_count = 0, n_tests = 0;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    ovr_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .first_output_sense_raw(raw_a), .second_output_sense_raw(raw_b),
        .first_output_sense_trimmed(trim_a),
        .second_output_sense_trimmed(trim_b),
        .first_output_ref(ref_a), .second_output_ref(ref_b),
        .first_output_error(err_a), .second_output_error(err_b));
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic bus(input logic [15:0] idx, input logic wr,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= OVR_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= OVR_HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, {24'h0, d}, x);
    endtask : wr
    task automatic rd_chk(input string what, input logic [15:0] idx,
        input logic [31:0] exp);
        logic [31:0] x;
        bus(idx, 1'b0, 32'h0, x);
        chk(what, exp, x);
    endtask : rd_chk
    task automatic t_reset_values;
        for (logic [15:0] c = 16'h0; c < 16'h2; c++)
        begin
            rd_chk("upper limit", OVR_IDX_MAX_A + c, 32'h3f);
            rd_chk("lower limit", OVR_IDX_MIN_A + c, 32'h0);
        end
    endtask : t_reset_values
    // Write all first so an aliased decode shows on readback
    task automatic t_readback;
        logic [15:0] idx[5] = '{OVR_IDX_GAIN_A, OVR_IDX_MAX_A,
            OVR_IDX_MIN_A, OVR_IDX_REFH_A, OVR_IDX_REFL_A};
        for (int i = 0; i < 10; i++)
            wr(idx[i / 2] + 16'(i % 2), 8'(8'h13 * i + 8'h5a));
        wr(16'hfe28, 8'h77);
        for (int i = 0; i < 10; i++)
            rd_chk("register", idx[i / 2] + 16'(i % 2),
                32'(8'(8'h13 * i + 8'h5a)));
        rd_chk("unmapped", 16'hfe28, 32'h0);
    endtask : t_readback
    task automatic ref_is(input logic c, input logic [11:0] exp);
        repeat (4) @(posedge hclk);
        chk("reference", {20'h0, exp}, {20'h0, c ? ref_b : ref_a});
        rd_chk("effective", OVR_IDX_EFF_A + c, {20'h0, exp});
    endtask : ref_is
    task automatic t_ref_clamp(input logic c);
        wr(OVR_IDX_MAX_A + c, 8'h3f);
        wr(OVR_IDX_MIN_A + c, 8'h00);
        wr(OVR_IDX_REFH_A + c, 8'hab);
        wr(OVR_IDX_REFL_A + c, 8'hfc);
        ref_is(c, 12'habc);
        wr(OVR_IDX_MAX_A + c, 8'h20);
        ref_is(c, 12'h83f);
        wr(OVR_IDX_MAX_A + c, 8'h2a);
        ref_is(c, 12'habc);
        wr(OVR_IDX_MIN_A + c, 8'h30);
        ref_is(c, 12'hc00);
        wr(OVR_IDX_MIN_A + c, 8'h2a);
        ref_is(c, 12'habc);
    endtask : t_ref_clamp
    task automatic t_gain(input logic c);
        logic [7:0] g[6] = '{8'h00, 8'h40, 8'hc0, 8'h7f, 8'hff, 8'h7f};
        logic [11:0] e[6] = '{12'h800, 12'h880, 12'h780, 12'h8fe, 12'h702,
            12'hfff};
        logic [12:0] d;
        for (int i = 0; i < 6; i++)
        begin
            if (c)
                raw_b <= i == 5 ? 12'hfff : 12'h800;
            else
                raw_a <= i == 5 ? 12'hfff : 12'h800;
            wr(OVR_IDX_GAIN_A + c, g[i]);
            repeat (4) @(posedge hclk);
            d = {1'b0, 12'habc} - {1'b0, e[i]};
            chk("trimmed", {20'h0, e[i]}, {20'h0, c ? trim_b : trim_a});
            chk("error", {19'h0, d}, {19'h0, c ? err_b : err_a});
            rd_chk("sense", OVR_IDX_SENSE_A + c, {20'h0, e[i]});
        end
    endtask : t_gain
    // Second reset after limits were moved away from defaults
    task automatic t_reset_again;
        wr(OVR_IDX_REFH_A, 8'h55);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("high byte", OVR_IDX_REFH_A, {24'h0, OVR_RST_REFH});
        t_reset_values();
    endtask : t_reset_again
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_readback();
        for (int c = 0; c < 2; c++)
        begin
            t_ref_clamp(c[0]);
            t_gain(c[0]);
        end
        t_reset_again();
        summarize();
    end
    initial
    begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule : ovr_regs_bench
